// [rtl/pwmtb_pkg.sv]
// pwmtb_pkg: constants and types for the pwm time-base control and status block
// assumes a 16-bit register port clocked by clk_i at 100 MHz
package pwmtb_pkg;

  localparam int unsigned PWMTB_AW = 8;
  localparam int unsigned PWMTB_DW = 16;

  // register byte offsets
  localparam logic [7:0] PWMTB_OFF_CONTROL = 8'h00;
  localparam logic [7:0] PWMTB_OFF_STATUS = 8'h04;
  localparam logic [7:0] PWMTB_OFF_PHASE = 8'h08;
  localparam logic [7:0] PWMTB_OFF_PERIOD = 8'h0C;
  localparam logic [7:0] PWMTB_OFF_COUNT = 8'h10;

  // control field positions
  localparam int unsigned PWMTB_CTL_MODE_LSB = 0;
  localparam int unsigned PWMTB_CTL_PHASE_EN_BIT = 2;
  localparam int unsigned PWMTB_CTL_SW_SYNC_BIT = 6;
  localparam int unsigned PWMTB_CTL_HSP_LSB = 7;
  localparam int unsigned PWMTB_CTL_TICKDIV_LSB = 10;

  // status field positions
  localparam int unsigned PWMTB_STS_DIR_BIT = 0;
  localparam int unsigned PWMTB_STS_SYNC_BIT = 1;
  localparam int unsigned PWMTB_STS_MAX_BIT = 2;

  // reset values
  localparam logic [2:0] PWMTB_RST_HSP = 3'h1;
  localparam logic [2:0] PWMTB_RST_TICKDIV = 3'h0;
  localparam logic [15:0] PWMTB_RST_PHASE = 16'h0000;
  localparam logic [15:0] PWMTB_RST_PERIOD = 16'h0000;
  localparam logic [15:0] PWMTB_RST_COUNT = 16'h0000;
  localparam logic [15:0] PWMTB_COUNT_MAX = 16'hFFFF;
  localparam logic [10:0] PWMTB_RST_DIVCNT = 11'h000;

  typedef enum logic [1:0] {
    PWMTB_MODE_UP = 2'b00,
    PWMTB_MODE_DOWN = 2'b01,
    PWMTB_MODE_UPDOWN = 2'b10,
    PWMTB_MODE_FREEZE = 2'b11
  } pwmtb_mode_t;

  typedef struct packed {
    logic [2:0] tick_prescale;
    logic [2:0] high_speed_prescale;
    logic phase_load_enable;
    pwmtb_mode_t counter_mode_select;
  } pwmtb_ctrl_t;

  localparam pwmtb_ctrl_t PWMTB_RST_CTRL = '{
    tick_prescale: PWMTB_RST_TICKDIV,
    high_speed_prescale: PWMTB_RST_HSP,
    phase_load_enable: 1'b0,
    counter_mode_select: PWMTB_MODE_FREEZE
  };

endpackage

// [rtl/pwmtb_prescale.sv]
// pwmtb_prescale: makes the one-cycle time-base tick from the system clock
// assumes prescale codes come from registers on the same clock
`timescale 1ns/10ps
module pwmtb_prescale import pwmtb_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] high_speed_prescale_i,
  input wire logic [2:0] tick_prescale_i,
  output logic tick_o
);

  logic [10:0] div_cnt;
  logic [10:0] next_div_cnt;
  logic next_tick;
  logic [10:0] divisor;
  logic [3:0] hsp_div;

  // divisor is high-speed divisor times power-of-two tick divisor
  always_comb begin
    hsp_div = (high_speed_prescale_i == 3'h0) ? 4'h1 : {high_speed_prescale_i, 1'b0};
    divisor = 11'({7'h00, hsp_div} << tick_prescale_i);
    if (div_cnt == 11'h000) begin
      next_div_cnt = divisor - 11'h001;
      next_tick = 1'b1;
    end else begin
      next_div_cnt = div_cnt - 11'h001;
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_cnt <= PWMTB_RST_DIVCNT;
      tick_o <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick_o <= next_tick;
    end
  end

  chk_tick_spacing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick_o && (divisor != 11'h001) && $stable(divisor) |=> !tick_o)
    else $error("time-base tick repeated too soon");

endmodule // pwmtb_prescale

// [rtl/pwmtb_sync_in.sv]
// pwmtb_sync_in: brings the sync input pin into clk_i and makes a rising-edge pulse
// assumes the pin is asynchronous to clk_i
`timescale 1ns/10ps
module pwmtb_sync_in (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sync_input_i,
  output logic sync_pulse_o
);

  logic meta;
  logic sync_q;
  logic sync_d;
  logic next_pulse;

  always_comb begin
    next_pulse = sync_q && !sync_d;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta <= 1'b0;
      sync_q <= 1'b0;
      sync_d <= 1'b0;
      sync_pulse_o <= 1'b0;
    end else begin
      meta <= sync_input_i;
      sync_q <= meta;
      sync_d <= sync_q;
      sync_pulse_o <= next_pulse;
    end
  end

  chk_sync_pulse_one: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sync_pulse_o |=> !sync_pulse_o)
    else $error("sync pulse longer than one cycle");

endmodule // pwmtb_sync_in

// [rtl/pwmtb_core.sv]
// pwmtb_core: pwm time-base counter with control and status registers
// assumes a register port master on clk_i and a sync pin from a neighbour module
// Operation
// - phase enabled: sync loads count from phase
// - phase disabled: count never loaded from phase
// - mode 00 up, 01 down, 10 updown, 11 frozen
// - mode change acts at next tick, keeps count
// - count reaching FFFF latches max flag
// - writing zero leaves max flag unchanged
// - external sync latches sync flag, write-one clears
// - direction flag one up, zero down
// - software sync write-one pulses, reads zero
// - tick is clock over both prescale divisors
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/10ps
module pwmtb_core import pwmtb_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [PWMTB_AW-1:0] reg_addr_i,
  input wire logic [PWMTB_DW-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [PWMTB_DW-1:0] reg_rdata_o,
  input wire logic sync_input_i,
  output logic [15:0] time_base_count_o,
  output logic count_direction_flag_o,
  output logic count_max_latched_o,
  output logic sync_seen_latched_o
);

  pwmtb_ctrl_t ctrl;
  pwmtb_ctrl_t next_ctrl;
  logic [15:0] phase_value;
  logic [15:0] next_phase_value;
  logic [15:0] period_value;
  logic [15:0] next_period_value;
  logic [15:0] count;
  logic [15:0] next_count;
  logic dir_up;
  logic next_dir_up;
  logic cnt_max;
  logic next_cnt_max;
  logic sync_seen;
  logic next_sync_seen;
  logic sw_sync;
  logic next_sw_sync;
  logic [PWMTB_DW-1:0] next_rdata;

  logic time_base_tick;
  logic ext_sync;
  logic sync_evt;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_count;

  pwmtb_prescale u_prescale (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .high_speed_prescale_i(ctrl.high_speed_prescale),
    .tick_prescale_i(ctrl.tick_prescale),
    .tick_o(time_base_tick)
  );

  pwmtb_sync_in u_sync_in (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .sync_input_i(sync_input_i),
    .sync_pulse_o(ext_sync)
  );

  // write decode
  always_comb begin
    wr_ctrl = reg_we_i && (reg_addr_i == PWMTB_OFF_CONTROL);
    wr_stat = reg_we_i && (reg_addr_i == PWMTB_OFF_STATUS);
    wr_count = reg_we_i && (reg_addr_i == PWMTB_OFF_COUNT);
    sync_evt = ext_sync || sw_sync;
  end

  // control, phase and period registers
  always_comb begin
    next_ctrl = ctrl;
    next_phase_value = phase_value;
    next_period_value = period_value;
    next_sw_sync = 1'b0;
    if (wr_ctrl) begin
      next_ctrl.counter_mode_select = pwmtb_mode_t'(reg_wdata_i[PWMTB_CTL_MODE_LSB +: 2]);
      next_ctrl.phase_load_enable = reg_wdata_i[PWMTB_CTL_PHASE_EN_BIT];
      next_ctrl.high_speed_prescale = reg_wdata_i[PWMTB_CTL_HSP_LSB +: 3];
      next_ctrl.tick_prescale = reg_wdata_i[PWMTB_CTL_TICKDIV_LSB +: 3];
      next_sw_sync = reg_wdata_i[PWMTB_CTL_SW_SYNC_BIT];
    end else if (reg_we_i && (reg_addr_i == PWMTB_OFF_PHASE)) begin
      next_phase_value = reg_wdata_i;
    end else if (reg_we_i && (reg_addr_i == PWMTB_OFF_PERIOD)) begin
      next_period_value = reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl <= PWMTB_RST_CTRL;
      phase_value <= PWMTB_RST_PHASE;
      period_value <= PWMTB_RST_PERIOD;
      sw_sync <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      phase_value <= next_phase_value;
      period_value <= next_period_value;
      sw_sync <= next_sw_sync;
    end
  end

  // counter and direction; mode is sampled only on a tick
  always_comb begin
    next_count = count;
    next_dir_up = dir_up;
    if (sync_evt && ctrl.phase_load_enable) begin
      next_count = phase_value;
    end else if (wr_count) begin
      next_count = reg_wdata_i;
    end else if (time_base_tick) begin
      case (ctrl.counter_mode_select)
        PWMTB_MODE_UP: begin
          next_dir_up = 1'b1;
          next_count = (count >= period_value) ? 16'h0000 : count + 16'h0001;
        end
        PWMTB_MODE_DOWN: begin
          next_dir_up = 1'b0;
          next_count = (count == 16'h0000) ? period_value : count - 16'h0001;
        end
        PWMTB_MODE_UPDOWN: begin
          if (dir_up) begin
            if (count >= period_value) begin
              next_dir_up = 1'b0;
              next_count = (count == 16'h0000) ? count : count - 16'h0001;
            end else begin
              next_count = count + 16'h0001;
            end
          end else begin
            if (count == 16'h0000) begin
              next_dir_up = 1'b1;
              next_count = (period_value == 16'h0000) ? count : count + 16'h0001;
            end else begin
              next_count = count - 16'h0001;
            end
          end
        end
        default: begin
          next_count = count;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= PWMTB_RST_COUNT;
      dir_up <= 1'b1;
    end else begin
      count <= next_count;
      dir_up <= next_dir_up;
    end
  end

  // latched status flags, set beats write-one clear
  always_comb begin
    next_cnt_max = cnt_max;
    next_sync_seen = sync_seen;
    if (wr_stat && reg_wdata_i[PWMTB_STS_MAX_BIT]) begin
      next_cnt_max = 1'b0;
    end
    if (wr_stat && reg_wdata_i[PWMTB_STS_SYNC_BIT]) begin
      next_sync_seen = 1'b0;
    end
    if (count == PWMTB_COUNT_MAX) begin
      next_cnt_max = 1'b1;
    end
    if (ext_sync) begin
      next_sync_seen = 1'b1;
    end
  end

  // register read, data one cycle later
  always_comb begin
    next_rdata = '0;
    if (reg_re_i) begin
      if (reg_addr_i == PWMTB_OFF_CONTROL) begin
        next_rdata[PWMTB_CTL_MODE_LSB +: 2] = ctrl.counter_mode_select;
        next_rdata[PWMTB_CTL_PHASE_EN_BIT] = ctrl.phase_load_enable;
        next_rdata[PWMTB_CTL_HSP_LSB +: 3] = ctrl.high_speed_prescale;
        next_rdata[PWMTB_CTL_TICKDIV_LSB +: 3] = ctrl.tick_prescale;
      end else if (reg_addr_i == PWMTB_OFF_STATUS) begin
        next_rdata[PWMTB_STS_DIR_BIT] = dir_up;
        next_rdata[PWMTB_STS_SYNC_BIT] = sync_seen;
        next_rdata[PWMTB_STS_MAX_BIT] = cnt_max;
      end else if (reg_addr_i == PWMTB_OFF_PHASE) begin
        next_rdata = phase_value;
      end else if (reg_addr_i == PWMTB_OFF_PERIOD) begin
        next_rdata = period_value;
      end else if (reg_addr_i == PWMTB_OFF_COUNT) begin
        next_rdata = count;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_max <= 1'b0;
      sync_seen <= 1'b0;
      reg_rdata_o <= '0;
      time_base_count_o <= PWMTB_RST_COUNT;
      count_direction_flag_o <= 1'b1;
      count_max_latched_o <= 1'b0;
      sync_seen_latched_o <= 1'b0;
    end else begin
      cnt_max <= next_cnt_max;
      sync_seen <= next_sync_seen;
      reg_rdata_o <= next_rdata;
      time_base_count_o <= next_count;
      count_direction_flag_o <= next_dir_up;
      count_max_latched_o <= next_cnt_max;
      sync_seen_latched_o <= next_sync_seen;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_sw_sync_write;
    wr_ctrl && reg_wdata_i[PWMTB_CTL_SW_SYNC_BIT];
  endsequence

  sequence s_quiet_tick;
    time_base_tick && !sync_evt && !wr_count;
  endsequence

  chk_phase_load: assert property (sync_evt && ctrl.phase_load_enable |=> count == $past(phase_value))
    else $error("phase value not loaded on sync");

  chk_no_phase: assert property (!ctrl.phase_load_enable && !wr_count && !time_base_tick
    |=> count == $past(count))
    else $error("count changed without tick or write");

  chk_freeze_hold: assert property (s_quiet_tick and (ctrl.counter_mode_select == PWMTB_MODE_FREEZE)
    |=> $stable(count))
    else $error("frozen counter moved");

  chk_up_wrap: assert property (s_quiet_tick and (ctrl.counter_mode_select == PWMTB_MODE_UP)
    and (count >= period_value) |=> count == 16'h0000 && dir_up)
    else $error("up count did not wrap at period");

  chk_down_dir: assert property (s_quiet_tick and (ctrl.counter_mode_select == PWMTB_MODE_DOWN)
    |=> !dir_up ##1 !count_direction_flag_o || $past(time_base_tick))
    else $error("direction flag wrong in down mode");

  chk_max_set: assert property (count == PWMTB_COUNT_MAX |=> cnt_max ##0 count_max_latched_o)
    else $error("count max flag not latched");

  chk_max_hold: assert property (cnt_max && !(wr_stat && reg_wdata_i[PWMTB_STS_MAX_BIT]) |=> cnt_max)
    else $error("count max flag lost without clear");

  chk_sync_set_wins: assert property (ext_sync && wr_stat |=> sync_seen && sync_seen_latched_o)
    else $error("sync flag lost against clear");

  chk_sync_clear: assert property (wr_stat && reg_wdata_i[PWMTB_STS_SYNC_BIT] && !ext_sync |=> !sync_seen)
    else $error("sync flag not cleared by write one");

  chk_sw_pulse: assert property (s_sw_sync_write |=> sw_sync ##1 !sw_sync || $past(wr_ctrl))
    else $error("software sync pulse wrong");

  chk_sw_reads_zero: assert property (reg_re_i && reg_addr_i == PWMTB_OFF_CONTROL
    |=> !reg_rdata_o[PWMTB_CTL_SW_SYNC_BIT])
    else $error("software sync bit read back as one");

  chk_count_waits_tick: assert property (!time_base_tick && !sync_evt && !wr_count |=> $stable(count))
    else $error("count moved between ticks");

  chk_no_phase_frozen: assert property (sync_evt && !ctrl.phase_load_enable && !wr_count
    && (ctrl.counter_mode_select == PWMTB_MODE_FREEZE) |=> $stable(count))
    else $error("frozen count loaded with phase disabled");

  chk_up_dir: assert property (s_quiet_tick and (ctrl.counter_mode_select == PWMTB_MODE_UP)
    |=> dir_up && count_direction_flag_o)
    else $error("direction flag wrong in up mode");

  chk_down_reload: assert property (s_quiet_tick and (ctrl.counter_mode_select == PWMTB_MODE_DOWN)
    and (count == 16'h0000) |=> count == $past(period_value))
    else $error("down count did not reload period");

  chk_updown_top: assert property (s_quiet_tick and (ctrl.counter_mode_select == PWMTB_MODE_UPDOWN)
    and (dir_up && count >= period_value && period_value != 16'h0000)
    |=> !dir_up && count == $past(count) - 16'h0001)
    else $error("updown count did not turn at period");

  chk_updown_bottom: assert property (s_quiet_tick and (ctrl.counter_mode_select == PWMTB_MODE_UPDOWN)
    and (!dir_up && count == 16'h0000 && period_value != 16'h0000)
    |=> dir_up && count == 16'h0001)
    else $error("updown count did not turn at zero");

  chk_sync_set: assert property (ext_sync |=> sync_seen && sync_seen_latched_o)
    else $error("sync flag not latched");

endmodule // pwmtb_core

// [sim/pwmtb_sync_peer.sv]
// pwmtb_sync_peer: neighbouring module driving the sync pin
// assumes requests on fire_i are spaced so the pin rests low two clocks or more
`timescale 1ns/10ps
module pwmtb_sync_peer (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic fire_i,
  input wire logic slow_i,
  output logic sync_o
);
  logic [2:0] hold;
  // pin high one clock, or five when slow
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) hold <= 3'h0;
    else if (fire_i && hold == 3'h0) hold <= slow_i ? 3'h5 : 3'h1;
    else if (hold != 3'h0) hold <= hold - 3'h1;
  end
  assign sync_o = (hold != 3'h0);
endmodule // pwmtb_sync_peer

// [sim/pwm_time_base_control_status_tb.sv]
// testbench: register port, sync peer and counter checks
// assumes prescale codes zero give one tick per clock
`timescale 1ns/10ps
module pwm_time_base_control_status_tb import pwmtb_pkg::*;;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic fire = 1'b0;
  logic slow = 1'b0;
  logic sync_w, dir, cmax, sseen;
  logic [15:0] rdata, cnt, v, ph;
  int errors = 0;
  int n_tests = 0;
  int seed = 95826;
  int gap = 0;
  always #5 clk_i = ~clk_i;
  pwmtb_core i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .sync_input_i(sync_w), .time_base_count_o(cnt),
    .count_direction_flag_o(dir), .count_max_latched_o(cmax), .sync_seen_latched_o(sseen));
  pwmtb_sync_peer i_peer (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .fire_i(fire), .slow_i(slow), .sync_o(sync_w));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic pulse_peer(logic s);
    int k;
    @(posedge clk_i);
    fire <= 1'b1;
    slow <= s;
    @(posedge clk_i);
    fire <= 1'b0;
    for (k = 0; k < 12 && sseen !== 1'b1; k++) tick(1);
  endtask
  function automatic logic [15:0] ctl(pwmtb_mode_t m, logic pen, logic sw);
    return {3'h0, 3'h0, 3'h0, sw, 3'h0, pen, m};
  endfunction
  function automatic logic [15:0] step(pwmtb_mode_t m, logic [15:0] c, logic [15:0] p);
    if (m == PWMTB_MODE_UP) return (c >= p) ? 16'h0000 : c + 16'h0001;
    return (c == 16'h0000) ? p : c - 16'h0001;
  endfunction
  task automatic run(pwmtb_mode_t m, int n);
    logic [15:0] p, c, prev, hi, lo;
    int k;
    p = 16'h0008 + 16'($random(seed) & 15);
    c = (m == PWMTB_MODE_UP) ? p - 16'($random(seed) & 7) : 16'($random(seed) & 7);
    if (m == PWMTB_MODE_UPDOWN) c = p >> 1;
    hi = c;
    lo = c;
    wr(PWMTB_OFF_PERIOD, p);
    wr(PWMTB_OFF_COUNT, c);
    tick(1);
    chk("count write", cnt, c);
    wr(PWMTB_OFF_CONTROL, ctl(m, 1'b0, 1'b0)); // mode set from frozen only
    for (k = 0; k < 8 && cnt === c; k++) tick(1);
    if (m != PWMTB_MODE_UPDOWN) chk("first step", cnt, step(m, c, p));
    for (k = 0; k < n; k++) begin
      prev = cnt;
      tick(1);
      if (cnt > hi) hi = cnt;
      if (cnt < lo) lo = cnt;
      if (m == PWMTB_MODE_UPDOWN) begin
        chk("updown step", 16'(cnt - prev == 16'h0001 || prev - cnt == 16'h0001), 16'h0001);
        chk("updown direction", 16'(dir), 16'(cnt > prev));
      end else begin
        chk("step", cnt, step(m, prev, p));
        chk("direction", 16'(dir), 16'(m == PWMTB_MODE_UP));
      end
    end
    if (m == PWMTB_MODE_UPDOWN) begin
      chk("updown top", hi, p);
      chk("updown bottom", lo, 16'h0000);
    end
    wr(PWMTB_OFF_CONTROL, ctl(PWMTB_MODE_FREEZE, 1'b0, 1'b0));
    tick(2);
    prev = cnt;
    tick(4);
    chk("frozen", cnt, prev);
    $display("test mode %0d done", m);
  endtask
  initial begin
    #100000;
    errors++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(PWMTB_OFF_CONTROL, v);
    chk("control reset", v, 16'h0083);
    rd(PWMTB_OFF_STATUS, v);
    chk("status reset", v, 16'h0001);
    rd(8'h20, v);
    chk("unmapped", v, 16'h0000);
    $display("test reset done");
    ph = 16'($random(seed));
    wr(PWMTB_OFF_PHASE, ph);
    wr(PWMTB_OFF_CONTROL, ctl(PWMTB_MODE_FREEZE, 1'b1, 1'b1));
    tick(3);
    chk("soft sync load", cnt, ph);
    chk("soft sync no flag", 16'(sseen), 16'h0000);
    rd(PWMTB_OFF_CONTROL, v);
    chk("soft bit reads zero", v, ctl(PWMTB_MODE_FREEZE, 1'b1, 1'b0));
    wr(PWMTB_OFF_COUNT, ~ph);
    pulse_peer(1'b0);
    chk("sync flag set", 16'(sseen), 16'h0001);
    chk("pin sync load", cnt, ph);
    wr(PWMTB_OFF_STATUS, 16'h0000);
    rd(PWMTB_OFF_STATUS, v);
    chk("sync flag kept", v & 16'h0002, 16'h0002);
    wr(PWMTB_OFF_STATUS, 16'h0002);
    tick(1);
    chk("sync flag clear", 16'(sseen), 16'h0000);
    $display("test phase enabled done");
    wr(PWMTB_OFF_COUNT, ~ph);
    wr(PWMTB_OFF_CONTROL, ctl(PWMTB_MODE_FREEZE, 1'b0, 1'b1));
    pulse_peer(1'b1);
    chk("no load", cnt, ~ph);
    chk("sync flag again", 16'(sseen), 16'h0001);
    wr(PWMTB_OFF_STATUS, 16'h0002);
    @(posedge clk_i);
    fire <= 1'b1;
    slow <= 1'b0;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (2) @(posedge clk_i);
    // clear lands on the edge of the internal sync pulse
    wr(PWMTB_OFF_STATUS, 16'h0002);
    tick(1);
    chk("set beats clear", 16'(sseen), 16'h0001);
    $display("test phase disabled done");
    repeat (2) begin
      run(PWMTB_MODE_UP, 24);
      run(PWMTB_MODE_DOWN, 24);
      run(PWMTB_MODE_UPDOWN, 60);
    end
    wr(PWMTB_OFF_STATUS, 16'h0006);
    wr(PWMTB_OFF_PERIOD, 16'hFFFF);
    wr(PWMTB_OFF_COUNT, 16'hFFFD);
    tick(1);
    chk("max flag clear", 16'(cmax), 16'h0000);
    wr(PWMTB_OFF_CONTROL, ctl(PWMTB_MODE_UP, 1'b0, 1'b0));
    tick(6);
    wr(PWMTB_OFF_CONTROL, ctl(PWMTB_MODE_FREEZE, 1'b0, 1'b0));
    chk("max flag set", 16'(cmax), 16'h0001);
    wr(PWMTB_OFF_STATUS, 16'h0000);
    rd(PWMTB_OFF_STATUS, v);
    chk("max write zero", v & 16'h0004, 16'h0004);
    wr(PWMTB_OFF_STATUS, 16'h0004);
    rd(PWMTB_OFF_STATUS, v);
    chk("max write one", v & 16'h0004, 16'h0000);
    $display("test max flag done");
    // prescale codes 2 and 1 give four times two clocks per tick
    wr(PWMTB_OFF_CONTROL, ctl(PWMTB_MODE_UP, 1'b0, 1'b0) | (16'h0002 << PWMTB_CTL_HSP_LSB)
      | (16'h0001 << PWMTB_CTL_TICKDIV_LSB));
    tick(12);
    v = cnt;
    for (gap = 0; gap < 40 && cnt === v; gap++) tick(1);
    v = cnt;
    for (gap = 0; gap < 40 && cnt === v; gap++) tick(1);
    chk("tick spacing", 16'(gap), 16'h0008);
    wr(PWMTB_OFF_CONTROL, ctl(PWMTB_MODE_FREEZE, 1'b0, 1'b0));
    $display("test tick rate done");
    complete_run();
  end
endmodule // pwm_time_base_control_status_tb
